// >>> verification/standby_wake_source_detector_bench.sv
// self-checking bench for the standby wake source detector
`timescale 1ns/10ps

module standby_wake_source_detector_bench;
    import wake_detect_pkg::*;
    logic        clock_i;
    logic        resetn_i;
    logic        clk_en_i;
    logic [3:0]  reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic [7:0]  wake_input_i;
    logic        standby_release_o;
    int          n_errors;
    int          samples_checked;
    int          cycles;

    standby_wake_source_detector dut (
        .clock_i          (clock_i),
        .resetn_i         (resetn_i),
        .clk_en_i         (clk_en_i),
        .reg_addr_i       (reg_addr_i),
        .reg_wdata_i      (reg_wdata_i),
        .reg_wr_i         (reg_wr_i),
        .reg_rd_i         (reg_rd_i),
        .reg_rdata_o      (reg_rdata_o),
        .wake_input_i     (wake_input_i),
        .standby_release_o(standby_release_o)
    );
    wake_pins_model pins (.clock_i(clock_i), .wake_o(wake_input_i));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    task check(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the read edge
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1 check("read data", e, reg_rdata_o);
    endtask : rd

    // sync plus pending plus output register stays well inside 8 edges
    task rel(input logic e);
        for (int k = 0; k < 8 && standby_release_o !== e; k++)
            @(posedge clock_i);
        #1 check("release", {31'h0, e}, {31'h0, standby_release_o});
    endtask : rel

    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // whole sequence needs well under a thousand cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    initial begin
        resetn_i = 1'b0;
        clk_en_i = 1'b1;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd(4'h0, 32'h20202020);
        rd(4'h4, 32'h20202020);
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, 32'h00000000);
        // status, spare bits written high must not stick; enables stay 0
        wr(4'h0, 32'h8E9EBECE);
        rd(4'h0, 32'h00103040);
        pins.set_pin(1, 1'b1);
        repeat (8) @(posedge clock_i);
        rel(1'b0);
        pins.set_pin(1, 1'b0);
        wr(4'h0, 32'h00103140);
        pins.set_pin(1, 1'b1);
        rel(1'b1);
        rd(4'hC, 32'h00000002);
        rd(4'h0, 32'h00103140);
        wr(4'h8, 32'h00000002);
        rel(1'b0);
        wr(4'h0, 32'h00103041);
        pins.set_pin(0, 1'b1);
        rel(1'b1);
        pins.set_pin(0, 1'b0);
        repeat (6) @(posedge clock_i);
        rd(4'h0, 32'h0010304D);
        wr(4'h8, 32'h00000001);
        rd(4'h0, 32'h00103041);
        rel(1'b0);
        wr(4'h4, 32'h40202020);
        wr(4'h4, 32'h41202020);
        pins.set_pin(7, 1'b1);
        pins.set_pin(7, 1'b0);
        rel(1'b1);
        repeat (6) @(posedge clock_i);
        rd(4'h4, 32'h4D202020);
        wr(4'h8, 32'h00000080);
        rd(4'h4, 32'h41202020);
        // clock enable low: a write in that window must be lost
        @(posedge clock_i) clk_en_i <= 1'b0;
        wr(4'h4, 32'h00000000);
        @(posedge clock_i) clk_en_i <= 1'b1;
        rd(4'h4, 32'h41202020);
        // low level held at clear: the request must stay up through the clear
        wr(4'h0, 32'h01103041);
        rel(1'b1);
        wr(4'h8, 32'h00000008);
        repeat (4) @(posedge clock_i);
        rel(1'b1);
        pins.set_pin(3, 1'b1);
        repeat (4) @(posedge clock_i);
        wr(4'h8, 32'h00000008);
        rel(1'b0);
        // source 2 on high level, then source 4 on falling edge
        pins.set_pin(2, 1'b1);
        wr(4'h0, 32'h01113041);
        rel(1'b1);
        pins.set_pin(2, 1'b0);
        repeat (4) @(posedge clock_i);
        wr(4'h8, 32'h00000004);
        rel(1'b0);
        wr(4'h4, 32'h41202021);
        pins.set_pin(4, 1'b1);
        repeat (4) @(posedge clock_i);
        rel(1'b0);
        pins.set_pin(4, 1'b0);
        rel(1'b1);
        wr(4'h8, 32'h00000010);
        rel(1'b0);
        end_of_test();
    end
endmodule : standby_wake_source_detector_bench

// >>> verification/wake_pins_model.sv
// model of the external wake input pins driven toward the detector
`timescale 1ns/10ps

module wake_pins_model (
    // clock
    input  wire logic       clock_i,
    // wake pins, push-pull, never released
    output logic      [7:0] wake_o
);
    initial wake_o = 8'h00;

    // pins move just after an edge so the detector's synchroniser sees
    // a clean level
    task set_pin(input int idx, input logic v);
        @(posedge clock_i);
        wake_o[idx] <= v;
    endtask : set_pin
endmodule : wake_pins_model

// >>> verilog/standby_wake_source_detector.sv
// standby wake source detector: eight inputs, mode registers, release request
// Operation
// - level select 000 low, 001 high, 010 fall, 011 rise, 100 either edge
// - low register: sources 0-3 level select at 6-4,14-12,22-20,30-28
// - read-only edge status 01 rise, 10 fall, 11 both, at 3-2 etc
// - edge status is recorded only while level select is either edge
// - clearing a source's pending request also zeroes its edge status
// - high register holds sources 4-7 in the same layout
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "wake_detect_regs.svh"

module standby_wake_source_detector
    import wake_detect_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clock_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    // register port
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // external wake inputs and request
    input  wire logic [7:0]  wake_input_i,
    output logic             standby_release_o
);

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic       rst_meta_q;
    logic       rst_sync_q;
    logic [7:0] in_meta_q;
    logic [7:0] in_sync_q;
    logic [7:0] in_prev_q;
    logic       rst_n;

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // ------------------------------------------------------------
    // per-source state
    // ------------------------------------------------------------
    reg_req_t    req;
    wake_src_t   src_q [8];
    wake_src_t   src_d [8];
    logic [7:0]  clear_mask;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        release_d;
    logic        release_q;
    logic [7:0]  cond_met;

    assign req = '{addr:  reg_addr_i,
                   wdata: reg_wdata_i,
                   wr:    reg_wr_i,
                   rd:    reg_rd_i};

    // clear command: one bit per source, written as a pulse
    assign clear_mask = (req.wr && req.addr == `WAKE_OFS_CLEAR_CMD)
                        ? req.wdata[7:0] : 8'h00;

    always_comb begin
        logic [2:0] lvl;
        logic       rise;
        logic       fall;
        logic       hit;
        logic       in_wr;
        logic [7:0] lane;
        lvl   = 3'h0;
        rise  = 1'b0;
        fall  = 1'b0;
        hit   = 1'b0;
        in_wr = 1'b0;
        lane  = 8'h00;
        for (int i = 0; i < 8; i++) begin
            src_d[i] = src_q[i];
            lvl  = src_q[i].level;
            rise = in_sync_q[i] & ~in_prev_q[i];
            fall = ~in_sync_q[i] & in_prev_q[i];
            case (lvl)
                `WAKE_LEVEL_LOW:  hit = ~in_sync_q[i];
                `WAKE_LEVEL_HIGH: hit = in_sync_q[i];
                `WAKE_LEVEL_FALL: hit = fall;
                `WAKE_LEVEL_RISE: hit = rise;
                `WAKE_LEVEL_BOTH: hit = rise | fall;
                default:          hit = 1'b0; // prohibited codes do nothing
            endcase
            cond_met[i] = hit;
            // write of the owning control register
            in_wr = req.wr && ((i < 4 && req.addr == `WAKE_OFS_CTRL_LOW) ||
                    (i >= 4 && req.addr == `WAKE_OFS_CTRL_HIGH));
            lane = req.wdata[(i % 4) * `WAKE_LANE_WIDTH +: 8];
            if (in_wr) begin
                src_d[i].level  = lane[`WAKE_LEVEL_POS +: 3];
                src_d[i].enable = lane[`WAKE_ENABLE_POS];
            end
            // clear first so that a same-cycle event wins
            if (clear_mask[i]) begin
                src_d[i].pending = 1'b0;
                src_d[i].status  = `WAKE_STATUS_NONE;
            end
            if (src_q[i].enable && hit) begin
                src_d[i].pending = 1'b1;
                if (lvl == `WAKE_LEVEL_BOTH) begin
                    src_d[i].status = (clear_mask[i] ? 2'h0 : src_q[i].status)
                        | (rise ? `WAKE_STATUS_RISE : `WAKE_STATUS_NONE)
                        | (fall ? `WAKE_STATUS_FALL : `WAKE_STATUS_NONE);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read mux and release request
    // ------------------------------------------------------------
    always_comb begin
        rdata_d   = 32'h0000_0000;
        release_d = 1'b0;
        for (int i = 0; i < 8; i++) begin
            release_d = release_d | src_d[i].pending;
        end
        if (req.rd) begin
            case (req.addr)
                `WAKE_OFS_CTRL_LOW, `WAKE_OFS_CTRL_HIGH: begin
                    for (int k = 0; k < 4; k++) begin
                        // bits 7 and 1 of each lane read zero
                        rdata_d[k*8 +: 8] = (req.addr == `WAKE_OFS_CTRL_LOW)
                            ? {1'b0, src_q[k].level, src_q[k].status,
                               1'b0, src_q[k].enable}
                            : {1'b0, src_q[k+4].level, src_q[k+4].status,
                               1'b0, src_q[k+4].enable};
                    end
                end
                `WAKE_OFS_PENDING: begin
                    for (int k = 0; k < 8; k++) begin
                        rdata_d[k] = src_q[k].pending;
                    end
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_q <= 8'h00;
            in_sync_q <= 8'h00;
            in_prev_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            release_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                src_q[i] <= '{level: `WAKE_LEVEL_RESET,
                              status: `WAKE_STATUS_NONE,
                              enable: 1'b0, pending: 1'b0};
            end
        end else if (clk_en_i) begin
            in_meta_q <= wake_input_i;
            in_sync_q <= in_meta_q;
            in_prev_q <= in_sync_q;
            rdata_q   <= rdata_d;
            release_q <= release_d;
            for (int i = 0; i < 8; i++) begin
                src_q[i] <= src_d[i];
            end
        end
    end

    assign reg_rdata_o       = rdata_q;
    assign standby_release_o = release_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_reset_level;
        @(posedge clock_i) $rose(rst_n) |-> src_q[0].level == 3'h2;
    endproperty
    a_reset_level: assert property (p_reset_level)
        else $error("level select not 010 after reset");

    property p_release_held;
        @(posedge clock_i) disable iff (!rst_n)
        (release_q && clk_en_i && clear_mask == 8'h00) |=> release_q;
    endproperty
    a_release_held: assert property (p_release_held)
        else $error("release request dropped without clear");

    property p_status_only_both;
        @(posedge clock_i) disable iff (!rst_n)
        ($changed(src_q[0].status) && src_q[0].status != 2'h0)
            |-> $past(src_q[0].level) == 3'h4;
    endproperty
    a_status_only_both: assert property (p_status_only_both)
        else $error("edge status set outside either-edge mode");

    property p_clear_status;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && clear_mask[0] && !(src_q[0].enable && cond_met[0]))
            |=> src_q[0].status == 2'h0 && !src_q[0].pending;
    endproperty
    a_clear_status: assert property (p_clear_status)
        else $error("clear did not zero edge status");

    property p_rise_status;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && src_q[1].enable && src_q[1].level == 3'h4 &&
         in_sync_q[1] && !in_prev_q[1]) |=> src_q[1].status[0];
    endproperty
    a_rise_status: assert property (p_rise_status)
        else $error("rising edge not recorded");

    property p_disabled_quiet;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && !src_q[2].enable && !src_q[2].pending)
            |=> !src_q[2].pending;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("disabled source raised a request");

    // pending reads use bit 7 for source 7, so only control reads qualify
    property p_read_zero_bits;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && reg_rd_i &&
         (reg_addr_i == `WAKE_OFS_CTRL_LOW ||
          reg_addr_i == `WAKE_OFS_CTRL_HIGH))
            |=> (reg_rdata_o & 32'h8282_8282) == 32'h0000_0000;
    endproperty
    a_read_zero_bits: assert property (p_read_zero_bits)
        else $error("unused bit read as one");

    property p_high_write;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && reg_wr_i && reg_addr_i == `WAKE_OFS_CTRL_HIGH)
            |=> src_q[7].level == $past(reg_wdata_i[30:28]);
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("source 7 level select not stored");

    // outputs leave reset quiet at the first edge after internal release
    property p_reset_outputs;
        @(posedge clock_i) $rose(rst_n)
            |-> !standby_release_o && reg_rdata_o == 32'h0000_0000;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("outputs not quiet after reset");

    // a held low level keeps asking, even across a clear
    property p_low_level;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && src_q[3].enable && src_q[3].level == `WAKE_LEVEL_LOW &&
         !in_sync_q[3]) |=> src_q[3].pending;
    endproperty
    a_low_level: assert property (p_low_level)
        else $error("low level did not raise a request");

    property p_high_level;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && src_q[2].enable && src_q[2].level == `WAKE_LEVEL_HIGH &&
         in_sync_q[2]) |=> src_q[2].pending;
    endproperty
    a_high_level: assert property (p_high_level)
        else $error("high level did not raise a request");

    property p_fall_level;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && src_q[4].enable && src_q[4].level == `WAKE_LEVEL_FALL &&
         !in_sync_q[4] && in_prev_q[4]) |=> src_q[4].pending;
    endproperty
    a_fall_level: assert property (p_fall_level)
        else $error("falling edge did not raise a request");

    // status accumulates, so a fall must show in bit 1 whatever came before
    property p_fall_status;
        @(posedge clock_i) disable iff (!rst_n)
        (clk_en_i && src_q[0].enable && src_q[0].level == `WAKE_LEVEL_BOTH &&
         !in_sync_q[0] && in_prev_q[0]) |=> src_q[0].status[1];
    endproperty
    a_fall_status: assert property (p_fall_status)
        else $error("falling edge not recorded");

    c_release: cover property (@(posedge clock_i) $rose(release_q));
    c_both: cover property (@(posedge clock_i) src_q[0].status == 2'h3);
    c_clear: cover property (@(posedge clock_i) $fell(release_q));
    c_high: cover property (@(posedge clock_i) src_q[2].pending);
    c_frozen_write: cover property (@(posedge clock_i) !clk_en_i && reg_wr_i);

endmodule : standby_wake_source_detector

// >>> verilog/wake_detect_pkg.sv
// types shared by the standby wake source detector
package wake_detect_pkg;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [2:0] level;
        logic [1:0] status;
        logic       enable;
        logic       pending;
    } wake_src_t;

endpackage : wake_detect_pkg

// >>> verilog/wake_detect_regs.svh
// register offsets, field positions, reset values and codes for the wake detector
`ifndef WAKE_DETECT_REGS_SVH
`define WAKE_DETECT_REGS_SVH

`define WAKE_OFS_CTRL_LOW    4'h0
`define WAKE_OFS_CTRL_HIGH   4'h4
`define WAKE_OFS_CLEAR_CMD   4'h8
`define WAKE_OFS_PENDING     4'hC

`define WAKE_ENABLE_POS      0
`define WAKE_STATUS_POS      2
`define WAKE_LEVEL_POS       4
`define WAKE_LANE_WIDTH      8

`define WAKE_LEVEL_RESET     3'h2
`define WAKE_LEVEL_LOW       3'h0
`define WAKE_LEVEL_HIGH      3'h1
`define WAKE_LEVEL_FALL      3'h2
`define WAKE_LEVEL_RISE      3'h3
`define WAKE_LEVEL_BOTH      3'h4

`define WAKE_STATUS_NONE     2'h0
`define WAKE_STATUS_RISE     2'h1
`define WAKE_STATUS_FALL     2'h2

`endif
